// ---- core/board_address_decoder.sv ----
`timescale 1ns/1ps
// Operation
// - FC 0, 3, 4 select nothing
// - Data/program spaces select memory and I/O
// - CPU space: coprocessor and IACK only
// - Low addresses hit cacheable D32 DRAM
// - First four cycles go to ROM 1
// - DRAM top to EFFFFFFF is VMEbus
// - BBRAM plus clock image repeats per 2KB
// - Serial controller ports decoded and repeated
// - Ports map to controller channels A/B
// - Printer: write data, read status
// - Missing LAN times out
// - SCSI registers repeat, via peripheral chip
// - Coprocessor ID 1 selects coprocessor
// - A4-A0 pick coprocessor register width
// - Read-only writes ignored, write-only reads ones
// - Absent coprocessor gives F-line exception
// - A19-A16 all ones marks acknowledge
// - Handler picks source within level
// - VMEbus reaches only DRAM, globals, interrupter
// - Base field places DRAM window, wraps
// - High windows accept extended modifiers only
module board_address_decoder
  import board_decode_pkg::*;
#(
  parameter int   DRAM_MB       = DRAM_MB_DEFAULT,
  parameter logic LAN_FITTED    = 1'b1,
  parameter logic COPROC_FITTED = 1'b1
) (
  // Clock and reset.
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // Processor cycle.
  input  wire logic        cyc_start_i,
  input  wire logic [2:0]  function_code_lines_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        read_i,
  // Interrupt sources, one bit per level per source slot.
  input  wire logic [7:0]  irq_pending_i [8],
  // VMEbus slave access.
  input  wire logic        vme_cyc_start_i,
  input  wire logic [31:0] vme_addr_i,
  input  wire logic        vme_extended_i,
  input  wire logic        vme_ram_cycle_i,
  input  wire logic        vme_global_hit_i,
  input  wire logic        vme_iack_hit_i,
  input  wire logic [4:0]  ram_base_i,
  // Local decode.
  output target_e          target_o,
  output port_e            port_o,
  output logic             cache_inhibit_o,
  output space_e           vme_space_o,
  output logic [1:0]       serial_ctrl_o,
  output logic             serial_chan_b_o,
  output logic [4:0]       cp_reg_o,
  output logic             cp_suppress_o,
  output logic [2:0]       iack_level_o,
  output logic [2:0]       iack_source_o,
  output logic             iack_none_o,
  output logic             boot_done_o,
  // VMEbus slave decode.
  output logic             vme_dram_sel_o,
  output logic [31:0]      vme_dram_offset_o,
  output logic             vme_global_sel_o,
  output logic             vme_iack_sel_o
);

  localparam logic [31:0] DRAM_TOP = 32'((64'(DRAM_MB) << 20) - 64'h1);

  // Picks the lowest pending source at a level.
  function automatic logic [3:0] pick_source(input logic [7:0] pend);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (pend[i]) begin
        r = {1'b0, 3'(i)};
      end
    end
    return r;
  endfunction : pick_source

  // Coprocessor register access kind from A4-A0.
  function automatic cp_access_e cp_access(input logic [4:0] a);
    cp_access_e k;
    k = CP_RSVD;
    if (a[4:2] == 3'h4 || a[4:2] == 3'h6 || a[4:2] == 3'h7) begin
      k = CP_RW;
    end else begin
      case (a[4:1])
        4'h0, 4'h2, 4'hA: k = CP_RO;
        4'h1, 4'h5, 4'h7: k = CP_WO;
        4'h3:             k = CP_RW;
        default:          k = CP_RSVD;
      endcase
    end
    return k;
  endfunction : cp_access

  target_e    target_q,  target_d;
  port_e      port_q,    port_d;
  space_e     space_q,   space_d;
  logic       ci_q,      ci_d;
  logic [1:0] sctl_q,    sctl_d;
  logic       sch_q,     sch_d;
  logic [4:0] cpr_q,     cpr_d;
  logic       cps_q,     cps_d;
  logic [2:0] lvl_q,     lvl_d;
  logic [2:0] src_q,     src_d;
  logic       none_q,    none_d;
  logic [2:0] boot_q,    boot_d;
  logic       done_q,    done_d;
  logic       vdram_q,   vdram_d;
  logic [31:0] voff_q,   voff_d;
  logic       vglb_q,    vglb_d;
  logic       viak_q,    viak_d;
  logic       win_hit;
  logic [31:0] win_off;
  logic [4:0] blk;
  logic [3:0] pick;
  cp_access_e acc;

  vme_dram_window #(
    .DRAM_MB(DRAM_MB)
  ) u_window (
    .vme_addr_i     (vme_addr_i),
    .vme_extended_i (vme_extended_i),
    .vme_ram_cycle_i(vme_ram_cycle_i),
    .ram_base_i     (ram_base_i),
    .hit_o          (win_hit),
    .offset_o       (win_off)
  );

  // Boot counter: counts the first bus cycles after reset.
  always_comb begin
    boot_d = boot_q;
    if (cyc_start_i && boot_q != BOOT_CYCLES) begin
      boot_d = boot_q + 3'h1;
    end
    done_d = (boot_d == BOOT_CYCLES);
  end

  always_comb begin
    blk    = addr_i[15:11];
    pick   = pick_source(irq_pending_i[addr_i[3:1]]);
    acc    = cp_access(addr_i[4:0]);
    target_d = target_q;
    port_d   = port_q;
    space_d  = space_q;
    ci_d     = ci_q;
    sctl_d   = sctl_q;
    sch_d    = sch_q;
    cpr_d    = cpr_q;
    cps_d    = cps_q;
    lvl_d    = lvl_q;
    src_d    = src_q;
    none_d   = none_q;
    if (cyc_start_i) begin
      target_d = TGT_NONE;
      port_d   = PORT_D16;
      space_d  = SPACE_A32;
      ci_d     = 1'b1;
      sctl_d   = 2'h0;
      sch_d    = 1'b0;
      cpr_d    = 5'h00;
      cps_d    = 1'b0;
      src_d    = 3'h0;
      none_d   = 1'b0;
      lvl_d    = 3'h0;
      case (function_code_lines_i)
        FC_USER_DATA, FC_USER_PROG, FC_SUPER_DATA, FC_SUPER_PROG: begin
          if (addr_i <= DRAM_TOP) begin
            port_d = PORT_D32;
            if (boot_q != BOOT_CYCLES) begin
              target_d = TGT_ROM1;
              port_d   = PORT_D16;
            end else begin
              target_d = TGT_DRAM;
              ci_d     = 1'b0;
            end
          end else if (addr_i <= VME_TOP) begin
            target_d = TGT_VME;
            port_d   = PORT_D32;
            space_d  = (addr_i < A24_LIMIT) ? SPACE_A24 : SPACE_A32;
          end else if (addr_i <= VME_A24_D16_HI) begin
            target_d = TGT_VME;
            space_d  = SPACE_A24;
          end else if (addr_i <= VME_A32_D16_HI) begin
            target_d = TGT_VME;
          end else if (addr_i < ROM2_LO) begin
            target_d = TGT_ROM1;
          end else if (addr_i <= ROM2_HI) begin
            target_d = TGT_ROM2;
          end else if (addr_i >= SHORT_IO_LO) begin
            target_d = TGT_VME;
            space_d  = SPACE_A16;
          end else if (addr_i[31:16] == LOCAL_IO_PAGE) begin
            port_d = PORT_D8;
            case (blk)
              BLK_BBRAM, 5'h01: begin
                target_d = (addr_i[10:0] >= TOD_FIRST) ? TGT_TOD : TGT_BBRAM;
              end
              BLK_PERIPH: begin
                target_d = TGT_PERIPH;
                port_d   = (addr_i[5:4] == 2'h0) ? PORT_D32 : PORT_D16;
              end
              BLK_LAN: begin
                target_d = LAN_FITTED ? TGT_LAN : TGT_NONE;
                port_d   = PORT_D16;
              end
              BLK_BUSIF: begin
                target_d = TGT_BUSIF;
                port_d   = PORT_D16;
              end
              BLK_PRINTER: begin
                target_d = read_i ? TGT_PRN_STAT : TGT_PRN_DATA;
              end
              BLK_SER_A, BLK_SER_B: begin
                // Low pair of bytes is channel B, high pair channel A.
                sctl_d   = (blk == BLK_SER_A) ? 2'h1 : 2'h2;
                sch_d    = ~addr_i[1];
                target_d = (blk == BLK_SER_A) ? (addr_i[1] ? TGT_SER1 : TGT_SER2)
                                              : (addr_i[1] ? TGT_SER3 : TGT_SER4);
              end
              BLK_SCSI_0, BLK_SCSI_1: begin
                target_d = TGT_SCSI;
              end
              default: begin
                target_d = TGT_NONE;
              end
            endcase
          end
        end
        FC_CPU_SPACE: begin
          if (addr_i[19:16] == CPU_IACK_TYPE) begin
            target_d = TGT_IACK;
            lvl_d    = addr_i[3:1];
            src_d    = pick[2:0];
            none_d   = pick[3];
          end else if (addr_i[19:13] == CPU_COPROC_SEL) begin
            target_d = COPROC_FITTED ? TGT_COPROC : TGT_FLINE;
            cpr_d    = addr_i[4:0];
            port_d   = (acc == CP_RW && addr_i[4]) ? PORT_D32 : PORT_D16;
            cps_d    = (!read_i && acc == CP_RO) || (read_i && acc == CP_WO);
          end
        end
        default: begin
          target_d = TGT_NONE;
        end
      endcase
    end
  end

  // Only the three permitted resources answer the VMEbus.
  always_comb begin
    vdram_d = 1'b0;
    vglb_d  = 1'b0;
    viak_d  = 1'b0;
    voff_d  = voff_q;
    if (vme_cyc_start_i) begin
      vdram_d = win_hit;
      voff_d  = win_off;
      vglb_d  = vme_global_hit_i;
      viak_d  = vme_iack_hit_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      target_q <= TGT_NONE;
      port_q   <= PORT_D16;
      space_q  <= SPACE_A32;
      ci_q     <= 1'b1;
      sctl_q   <= 2'h0;
      sch_q    <= 1'b0;
      cpr_q    <= 5'h00;
      cps_q    <= 1'b0;
      lvl_q    <= 3'h0;
      src_q    <= 3'h0;
      none_q   <= 1'b0;
      boot_q   <= 3'h0;
      done_q   <= 1'b0;
      vdram_q  <= 1'b0;
      voff_q   <= 32'h0;
      vglb_q   <= 1'b0;
      viak_q   <= 1'b0;
    end else begin
      target_q <= target_d;
      port_q   <= port_d;
      space_q  <= space_d;
      ci_q     <= ci_d;
      sctl_q   <= sctl_d;
      sch_q    <= sch_d;
      cpr_q    <= cpr_d;
      cps_q    <= cps_d;
      lvl_q    <= lvl_d;
      src_q    <= src_d;
      none_q   <= none_d;
      boot_q   <= boot_d;
      done_q   <= done_d;
      vdram_q  <= vdram_d;
      voff_q   <= voff_d;
      vglb_q   <= vglb_d;
      viak_q   <= viak_d;
    end
  end

  assign target_o          = target_q;
  assign port_o            = port_q;
  assign cache_inhibit_o   = ci_q;
  assign vme_space_o       = space_q;
  assign serial_ctrl_o     = sctl_q;
  assign serial_chan_b_o   = sch_q;
  assign cp_reg_o          = cpr_q;
  assign cp_suppress_o     = cps_q;
  assign iack_level_o      = lvl_q;
  assign iack_source_o     = src_q;
  assign iack_none_o       = none_q;
  assign boot_done_o       = done_q;
  assign vme_dram_sel_o    = vdram_q;
  assign vme_dram_offset_o = voff_q;
  assign vme_global_sel_o  = vglb_q;
  assign vme_iack_sel_o    = viak_q;

  sequence s_reserved_fc;
    cyc_start_i && (function_code_lines_i == 3'h0 || function_code_lines_i == 3'h3 ||
                    function_code_lines_i == 3'h4);
  endsequence

  sequence s_user_space;
    cyc_start_i && function_code_lines_i != FC_CPU_SPACE && function_code_lines_i[1:0] != 2'h0 &&
    function_code_lines_i != 3'h3;
  endsequence

  chk_reserved_fc_none: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_reserved_fc |=> target_o == TGT_NONE) else $error("reserved function code selected a target");

  chk_user_no_cpu: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_user_space |=> target_o != TGT_IACK && target_o != TGT_COPROC) else $error("cpu target in memory space");

  chk_cpu_space_only: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    cyc_start_i && function_code_lines_i == FC_CPU_SPACE && addr_i[19:16] != 4'hF && addr_i[19:13] != 7'h11
    |=> target_o == TGT_NONE) else $error("unknown cpu space cycle answered");

  chk_boot_rom_first: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_user_space and (addr_i == 32'h0) and (!boot_done_o) |=> target_o == TGT_ROM1)
    else $error("boot cycle not sent to rom");

  chk_dram_after_boot: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_user_space and (addr_i == 32'h0) and boot_done_o |=> target_o == TGT_DRAM && !cache_inhibit_o && port_o == PORT_D32)
    else $error("dram not selected after boot");

  chk_vme_a24_low: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_user_space and (addr_i > DRAM_TOP) and (addr_i < A24_LIMIT) |=> vme_space_o == SPACE_A24 && target_o == TGT_VME)
    else $error("low vmebus cycle not a24");

  chk_printer_dir: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_user_space and (addr_i[31:11] == 21'h1FFFC5) |=> target_o == (read_i ? TGT_PRN_STAT : TGT_PRN_DATA))
    else $error("printer direction wrong");

  chk_iack_route: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    cyc_start_i && function_code_lines_i == FC_CPU_SPACE && addr_i[19:16] == 4'hF
    |=> target_o == TGT_IACK && iack_level_o == $past(addr_i[3:1])) else $error("acknowledge misrouted");

  chk_vme_fresh: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !vme_cyc_start_i |=> !vme_dram_sel_o && !vme_global_sel_o && !vme_iack_sel_o)
    else $error("vmebus select without access");

  chk_boot_count: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    boot_done_o |=> boot_done_o) else $error("boot window reopened");

endmodule : board_address_decoder

// ---- core/board_decode_pkg.sv ----
package board_decode_pkg;

  // Function codes.
  localparam logic [2:0] FC_USER_DATA  = 3'h1;
  localparam logic [2:0] FC_USER_PROG  = 3'h2;
  localparam logic [2:0] FC_SUPER_DATA = 3'h5;
  localparam logic [2:0] FC_SUPER_PROG = 3'h6;
  localparam logic [2:0] FC_CPU_SPACE  = 3'h7;

  // CPU space fields.
  localparam logic [3:0] CPU_IACK_TYPE  = 4'hF;
  localparam logic [6:0] CPU_COPROC_SEL = 7'h11;

  // Main map boundaries.
  localparam logic [31:0] VME_TOP       = 32'hEFFFFFFF;
  localparam logic [31:0] A24_LIMIT     = 32'h01000000;
  localparam logic [31:0] VME_A24_D16_LO = 32'hF0000000;
  localparam logic [31:0] VME_A24_D16_HI = 32'hF0FFFFFF;
  localparam logic [31:0] VME_A32_D16_HI = 32'hFF7FFFFF;
  localparam logic [31:0] ROM1_LO       = 32'hFF800000;
  localparam logic [31:0] ROM2_LO       = 32'hFFA00000;
  localparam logic [31:0] ROM2_HI       = 32'hFFBFFFFF;
  localparam logic [31:0] SHORT_IO_LO   = 32'hFFFF0000;
  localparam logic [15:0] LOCAL_IO_PAGE = 16'hFFFE;

  // Local I/O 2KB block numbers within the FFFE page (address bits 15:11).
  localparam logic [4:0] BLK_BBRAM   = 5'h00;
  localparam logic [4:0] BLK_PERIPH  = 5'h02;
  localparam logic [4:0] BLK_LAN     = 5'h03;
  localparam logic [4:0] BLK_BUSIF   = 5'h04;
  localparam logic [4:0] BLK_PRINTER = 5'h05;
  localparam logic [4:0] BLK_SER_A   = 5'h06;
  localparam logic [4:0] BLK_SER_B   = 5'h07;
  localparam logic [4:0] BLK_SCSI_0  = 5'h08;
  localparam logic [4:0] BLK_SCSI_1  = 5'h09;
  localparam logic [10:0] TOD_FIRST  = 11'h7F8;

  // Boot window length in bus cycles.
  localparam logic [2:0] BOOT_CYCLES = 3'h4;

  // RAM base field.
  localparam logic [4:0] RBA_WRAP0 = 5'h1C;
  localparam logic [4:0] RBA_WRAP1 = 5'h1D;
  localparam logic [4:0] RBA_LAST  = 5'h1B;

  // Default DRAM capacity in megabytes.
  localparam int DRAM_MB_DEFAULT = 4;

  // Selection targets.
  typedef enum logic [4:0] {
    TGT_NONE, TGT_DRAM, TGT_VME, TGT_ROM1, TGT_ROM2, TGT_BBRAM, TGT_TOD, TGT_PERIPH,
    TGT_LAN, TGT_BUSIF, TGT_PRN_DATA, TGT_PRN_STAT, TGT_SER1, TGT_SER2, TGT_SER3,
    TGT_SER4, TGT_SCSI, TGT_COPROC, TGT_IACK, TGT_FLINE
  } target_e;

  // Port widths.
  typedef enum logic [1:0] {
    PORT_D8, PORT_D16, PORT_D32
  } port_e;

  // VMEbus address space of an outbound cycle.
  typedef enum logic [1:0] {
    SPACE_A16, SPACE_A24, SPACE_A32
  } space_e;

  // Coprocessor register access kinds.
  typedef enum logic [1:0] {
    CP_RW, CP_RO, CP_WO, CP_RSVD
  } cp_access_e;

endpackage : board_decode_pkg

// ---- core/vme_dram_window.sv ----
`timescale 1ns/1ps
module vme_dram_window
  import board_decode_pkg::*;
#(
  parameter int DRAM_MB = DRAM_MB_DEFAULT
) (
  // Slave access.
  input  wire logic [31:0] vme_addr_i,
  input  wire logic        vme_extended_i,
  input  wire logic        vme_ram_cycle_i,
  // Base field.
  input  wire logic [4:0]  ram_base_i,
  // Result.
  output logic             hit_o,
  output logic [31:0]      offset_o
);

  localparam logic [32:0] CAP = 33'(DRAM_MB) << 20;

  logic [4:0]  slot;
  logic [32:0] base;
  logic [32:0] top;

  always_comb begin
    slot = ram_base_i;
    if (ram_base_i == RBA_WRAP0) begin
      slot = 5'h00;
    end else if (ram_base_i == RBA_WRAP1) begin
      slot = 5'h01;
    end
    base = 33'(slot) * CAP;
    top  = base + CAP;
    hit_o = 1'b0;
    // Windows at 16MB or above take only extended modifiers.
    if (vme_ram_cycle_i && ram_base_i <= RBA_WRAP1 &&
        ({1'b0, vme_addr_i} >= base) && ({1'b0, vme_addr_i} < top) &&
        (vme_extended_i || base < {1'b0, A24_LIMIT})) begin
      hit_o = 1'b1;
    end
    offset_o = vme_addr_i - base[31:0];
  end

endmodule : vme_dram_window

// ---- dv/cpu_bus_model.sv ----
`timescale 1ns/1ps
module cpu_bus_model
  import board_decode_pkg::*;
(
  // Clock.
  input  wire logic        sys_clk_i,
  // Processor bus cycle.
  output logic             cyc_start_o,
  output logic [2:0]       function_code_lines_o,
  output logic [31:0]      addr_o,
  output logic             read_o
);
  initial begin
    cyc_start_o = 1'b0;
    function_code_lines_o = 3'h0;
    addr_o = 32'h0;
    read_o = 1'b1;
  end

  // The strobe is held for exactly the edge that takes it; afterwards the address lines
  // show the inverse of the last value, so a decoder that samples late sees garbage.
  task automatic run_cycle(input logic [2:0] fc, input logic [31:0] a, input logic rd);
    @(posedge sys_clk_i);
    cyc_start_o <= 1'b1;
    function_code_lines_o <= fc;
    addr_o <= a;
    read_o <= rd;
    @(posedge sys_clk_i);
    cyc_start_o <= 1'b0;
    addr_o <= ~a;
    #1;
  endtask : run_cycle

  task automatic iack_cycle(input logic [2:0] level);
    run_cycle(FC_CPU_SPACE, {12'hFFF, 4'hF, 12'hFFF, level, 1'b1}, 1'b1);
  endtask : iack_cycle
endmodule : cpu_bus_model

// ---- dv/board_address_decoder_tb.sv ----
`timescale 1ns/1ps
module board_address_decoder_tb
  import board_decode_pkg::*;
  ;
  localparam int          MB      = 4;
  localparam logic [31:0] CAP     = 32'(MB) << 20;
  localparam logic [31:0] CP_BASE = 32'h00022000;

  typedef struct {logic [31:0] a; logic rd; target_e t; port_e p;} map_row_s;
  typedef struct {logic [4:0] base; int slot; logic [31:0] off; logic ext; logic ram; logic hit;} vme_row_s;

  logic        sys_clk_i;
  logic        resetn_i;
  logic        cyc_start;
  logic [2:0]  fc;
  logic [31:0] addr;
  logic        rd;
  logic [7:0]  irq_pending [8];
  logic        vme_start;
  logic [31:0] vme_addr;
  logic        vme_ext;
  logic        vme_ram;
  logic        vme_glob;
  logic        vme_iack;
  logic [4:0]  ram_base;
  target_e     tgt;
  target_e     tgt_nocp;
  port_e       port;
  logic        ci;
  space_e      space;
  logic [1:0]  ser_ctrl;
  logic        ser_b;
  logic [4:0]  cp_reg;
  logic        cp_sup;
  logic [2:0]  ilvl;
  logic [2:0]  isrc;
  logic        inone;
  logic        boot_done;
  logic        vdram;
  logic [31:0] voff;
  logic        vglob;
  logic        viack;
  int          n_mismatch;
  int          check_count;

  always #10 sys_clk_i = ~sys_clk_i;

  cpu_bus_model cpu_bus_model_inst (
    .sys_clk_i             (sys_clk_i),
    .cyc_start_o           (cyc_start),
    .function_code_lines_o (fc),
    .addr_o                (addr),
    .read_o                (rd)
  );

  // The LAN is left out so that its range must time out.
  board_address_decoder #(.DRAM_MB(MB), .LAN_FITTED(1'b0)) board_address_decoder_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cyc_start_i(cyc_start), .function_code_lines_i(fc),
    .addr_i(addr), .read_i(rd), .irq_pending_i(irq_pending), .vme_cyc_start_i(vme_start),
    .vme_addr_i(vme_addr), .vme_extended_i(vme_ext), .vme_ram_cycle_i(vme_ram), .vme_global_hit_i(vme_glob),
    .vme_iack_hit_i(vme_iack), .ram_base_i(ram_base), .target_o(tgt), .port_o(port), .cache_inhibit_o(ci),
    .vme_space_o(space), .serial_ctrl_o(ser_ctrl), .serial_chan_b_o(ser_b), .cp_reg_o(cp_reg),
    .cp_suppress_o(cp_sup), .iack_level_o(ilvl), .iack_source_o(isrc), .iack_none_o(inone),
    .boot_done_o(boot_done), .vme_dram_sel_o(vdram), .vme_dram_offset_o(voff), .vme_global_sel_o(vglob),
    .vme_iack_sel_o(viack)
  );

  // A second build with the LAN fitted but without the coprocessor, fed the same cycles.
  board_address_decoder #(.DRAM_MB(MB), .COPROC_FITTED(1'b0)) board_address_decoder_inst2 (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cyc_start_i(cyc_start), .function_code_lines_i(fc),
    .addr_i(addr), .read_i(rd), .irq_pending_i(irq_pending), .vme_cyc_start_i(vme_start),
    .vme_addr_i(vme_addr), .vme_extended_i(vme_ext), .vme_ram_cycle_i(vme_ram), .vme_global_hit_i(vme_glob),
    .vme_iack_hit_i(vme_iack), .ram_base_i(ram_base), .target_o(tgt_nocp), .port_o(), .cache_inhibit_o(),
    .vme_space_o(), .serial_ctrl_o(), .serial_chan_b_o(), .cp_reg_o(), .cp_suppress_o(), .iack_level_o(),
    .iack_source_o(), .iack_none_o(), .boot_done_o(), .vme_dram_sel_o(), .vme_dram_offset_o(),
    .vme_global_sel_o(), .vme_iack_sel_o()
  );

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_tgt(input target_e got, input target_e exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %s exp %s", $time, what, got.name(), exp.name());
    end
  endtask : cmp_tgt

  task automatic cyc(input logic [2:0] f, input logic [31:0] a, input logic r);
    cpu_bus_model_inst.run_cycle(f, a, r);
  endtask : cyc

  task automatic test_boot();
    for (int i = 0; i < 4; i++) begin
      cyc(FC_SUPER_PROG, 32'h00000100, 1'b1);
      cmp_tgt(tgt, TGT_ROM1, "boot rom");
      if (i < 3) cmp_val(32'(boot_done), 32'h0, "boot early");
    end
    cyc(FC_SUPER_DATA, CAP - 32'h4, 1'b1);
    cmp_tgt(tgt, TGT_DRAM, "dram top");
    cmp_val(32'(port), 32'(PORT_D32), "dram port");
    cmp_val(32'(ci), 32'h0, "dram cache");
    cmp_val(32'(boot_done), 32'h1, "boot done");
  endtask : test_boot

  task automatic test_fc();
    for (int f = 0; f < 7; f++) begin
      cyc(3'(f), 32'h00000000, 1'b0);
      cmp_tgt(tgt, (f == 0 || f == 3 || f == 4) ? TGT_NONE : TGT_DRAM, "fc");
    end
  endtask : test_fc

  task automatic test_map();
    map_row_s rows [24];
    space_e   sp;
    rows = '{'{CAP, 1, TGT_VME, PORT_D32}, '{32'hEFFFFFFC, 1, TGT_VME, PORT_D32},
      '{32'h02000000, 1, TGT_VME, PORT_D32}, '{32'hF0000000, 1, TGT_VME, PORT_D16},
      '{32'hFF7FFFFC, 1, TGT_VME, PORT_D16}, '{32'hFF800000, 1, TGT_ROM1, PORT_D16},
      '{32'hFFA00000, 1, TGT_ROM2, PORT_D16}, '{32'hFFC00000, 1, TGT_NONE, PORT_D16},
      '{32'hFFFE5000, 1, TGT_NONE, PORT_D16}, '{32'hFFFF0000, 0, TGT_VME, PORT_D16},
      '{32'hFFFE0000, 1, TGT_BBRAM, PORT_D8}, '{32'hFFFE07F8, 0, TGT_TOD, PORT_D8},
      '{32'hFFFE0FFF, 1, TGT_TOD, PORT_D8}, '{32'hFFFE0800, 1, TGT_BBRAM, PORT_D8},
      '{32'hFFFE1800, 1, TGT_NONE, PORT_D16}, '{32'hFFFE2800, 0, TGT_PRN_DATA, PORT_D8},
      '{32'hFFFE2800, 1, TGT_PRN_STAT, PORT_D8}, '{32'hFFFE2FFF, 1, TGT_PRN_STAT, PORT_D8},
      '{32'hFFFE4000, 1, TGT_SCSI, PORT_D8}, '{32'hFFFE4FE1, 0, TGT_SCSI, PORT_D8},
      '{32'hFFFE3000, 1, TGT_SER2, PORT_D8}, '{32'hFFFE37FE, 1, TGT_SER1, PORT_D8},
      '{32'hFFFE3800, 0, TGT_SER4, PORT_D8}, '{32'hFFFE3FFE, 1, TGT_SER3, PORT_D8}};
    foreach (rows[i]) begin
      cyc(FC_USER_DATA, rows[i].a, rows[i].rd);
      cmp_tgt(tgt, rows[i].t, "map");
      if (rows[i].a == 32'hFFFE1800) cmp_tgt(tgt_nocp, TGT_LAN, "lan fitted");
      if (rows[i].t != TGT_NONE) begin
        cmp_val(32'(port), 32'(rows[i].p), "map port");
        cmp_val(32'(ci), 32'h1, "map cache");
      end
      if (rows[i].t == TGT_VME) begin
        sp = (rows[i].a >= SHORT_IO_LO) ? SPACE_A16 :
             (rows[i].a < A24_LIMIT || rows[i].a[31:24] == 8'hF0) ? SPACE_A24 : SPACE_A32;
        cmp_val(32'(space), 32'(sp), "vme space");
      end
      if (rows[i].t inside {TGT_SER1, TGT_SER2, TGT_SER3, TGT_SER4}) begin
        cmp_val(32'(ser_ctrl), (rows[i].t inside {TGT_SER1, TGT_SER2}) ? 32'h1 : 32'h2, "ser ctrl");
        cmp_val(32'(ser_b), (rows[i].t inside {TGT_SER2, TGT_SER4}) ? 32'h1 : 32'h0, "ser chan");
      end
    end
  endtask : test_map

  task automatic test_cp();
    cyc(FC_CPU_SPACE, CP_BASE, 1'b1);
    cmp_tgt(tgt, TGT_COPROC, "cp sel");
    cmp_tgt(tgt_nocp, TGT_FLINE, "cp absent");
    cmp_val(32'(cp_sup), 32'h0, "cp ro read");
    cyc(FC_CPU_SPACE, CP_BASE, 1'b0);
    cmp_val(32'(cp_sup), 32'h1, "cp ro write");
    cyc(FC_CPU_SPACE, CP_BASE | 32'h2, 1'b1);
    cmp_val(32'(cp_sup), 32'h1, "cp wo read");
    for (int r = 0; r < 32; r++) begin
      cyc(FC_CPU_SPACE, CP_BASE | 32'(r), 1'b1);
      cmp_val(32'(cp_reg), 32'(r), "cp reg");
      cmp_val(32'(port), (r >= 16 && !(r >= 20 && r < 24)) ? 32'(PORT_D32) : 32'(PORT_D16), "cp port");
    end
    cyc(FC_CPU_SPACE, 32'h00024000, 1'b1);
    cmp_tgt(tgt, TGT_NONE, "cp other id");
    cyc(FC_CPU_SPACE, 32'h00000000, 1'b1);
    cmp_tgt(tgt, TGT_NONE, "breakpoint");
    cyc(FC_SUPER_DATA, CP_BASE, 1'b1);
    cmp_tgt(tgt, TGT_DRAM, "cp addr in data space");
  endtask : test_cp

  task automatic test_iack();
    @(posedge sys_clk_i);
    irq_pending[3] <= 8'h28;
    cpu_bus_model_inst.iack_cycle(3'h3);
    cmp_tgt(tgt, TGT_IACK, "iack");
    cmp_val(32'(ilvl), 32'h3, "iack level");
    cmp_val(32'(isrc), 32'h3, "iack source");
    cmp_val(32'(inone), 32'h0, "iack pending");
    cpu_bus_model_inst.iack_cycle(3'h5);
    cmp_val(32'(inone), 32'h1, "iack empty level");
  endtask : test_iack

  task automatic vme_acc(input logic [4:0] b, input logic [31:0] a, input logic e, input logic r,
                         input logic g, input logic k);
    @(posedge sys_clk_i);
    ram_base <= b;
    vme_addr <= a;
    vme_ext <= e;
    vme_ram <= r;
    vme_glob <= g;
    vme_iack <= k;
    vme_start <= 1'b1;
    @(posedge sys_clk_i);
    vme_start <= 1'b0;
    vme_addr <= ~a;
    #1;
  endtask : vme_acc

  task automatic test_vme();
    vme_row_s v [9];
    v = '{'{2, 2, 32'h10, 0, 1, 1}, '{2, 3, 32'h10, 1, 1, 0}, '{2, 2, 32'h10, 1, 0, 0},
      '{5, 5, 32'h20, 0, 1, 0}, '{5, 5, 32'h20, 1, 1, 1}, '{27, 27, CAP - 32'h4, 1, 1, 1},
      '{28, 0, 32'h40, 0, 1, 1}, '{29, 1, 32'h40, 0, 1, 1}, '{30, 30, 32'h0, 1, 1, 0}};
    foreach (v[i]) begin
      vme_acc(v[i].base, 32'(v[i].slot) * CAP + v[i].off, v[i].ext, v[i].ram, 1'b0, 1'b0);
      cmp_val(32'(vdram), 32'(v[i].hit), "vme dram sel");
      if (v[i].hit) cmp_val(voff, v[i].off, "vme offset");
      cmp_val(32'({vglob, viack}), 32'h0, "vme others");
    end
    @(posedge sys_clk_i);
    #1;
    cmp_val(32'(vdram), 32'h0, "vme pulse end");
    vme_acc(5'h2, 32'hFFFE0000, 1'b0, 1'b0, 1'b1, 1'b0);
    cmp_val(32'({vdram, vglob, viack}), 32'h2, "vme global");
    vme_acc(5'h2, 32'h00000003, 1'b0, 1'b0, 1'b0, 1'b1);
    cmp_val(32'({vdram, vglob, viack}), 32'h1, "vme iack");
  endtask : test_vme

  task automatic test_reset_again();
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    cmp_tgt(tgt, TGT_NONE, "reset target");
    cmp_val(32'(boot_done), 32'h0, "reset boot");
    @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    cyc(FC_SUPER_PROG, 32'h00000000, 1'b1);
    cmp_tgt(tgt, TGT_ROM1, "boot after reset");
  endtask : test_reset_again

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // The whole sequence needs well under a thousand cycles; this allows twenty times that.
  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end

  initial begin
    sys_clk_i = 1'b0;
    resetn_i = 1'b0;
    foreach (irq_pending[i]) irq_pending[i] = 8'h00;
    {vme_start, vme_ext, vme_ram, vme_glob, vme_iack} = 5'h00;
    vme_addr = 32'h0;
    ram_base = 5'h00;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    test_boot();
    test_fc();
    test_map();
    test_cp();
    test_iack();
    test_vme();
    test_reset_again();
    conclude();
  end
endmodule : board_address_decoder_tb
